//--- inc/aprx_pkg.sv
// How it works
// R1: Receive edge bit picks default or opposite edge
// R2: Controller mode frame sync from internal or pin
// R3: Controller mode bit clock from internal or pin
// R4: Offset delays slot 0 MSB by bit clocks
// R5: Rate code zero selects automatic rate detection
// R6: Codes 1 to 40 select fixed descending rates
// R7: Host avoids reserved codes, keeps rate in range
// R8: Auto detect tolerance 1 percent, widened 5 percent
// R9: Custom bit selects software or automatic dividers
// R10: Host drives external clocks steadily and consistently
package aprx_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] RX_CFG_ADDR    = 8'h26;
  localparam logic [7:0] CLK_CFG_ADDR   = 8'h32;
  localparam logic [7:0] RX_CFG_RESET   = 8'h00;
  localparam logic [7:0] CLK_CFG_RESET  = 8'h00;
  localparam int         EDGE_BIT       = 7;
  localparam int         INT_FS_BIT     = 6;
  localparam int         INT_BCLK_BIT   = 5;
  localparam int         OFFSET_MSB     = 4;
  localparam int         RATE_MSB       = 7;
  localparam int         RATE_LSB       = 2;
  localparam int         TOL_BIT        = 1;
  localparam int         CUSTOM_BIT     = 0;

  // ==========================================================
  // Timing and sizes
  localparam longint     MCLK_HZ        = 20000000;
  localparam int         WORD_BITS      = 16;
  localparam int         HALF_FRAME     = 32;
  localparam int         FIFO_DEPTH     = 16;
  localparam logic [5:0] RATE_AUTO      = 6'h00;
  localparam logic [5:0] RATE_CODE_MAX  = 6'h28;
  localparam logic [33:0] TOL1_LO = 34'(MCLK_HZ * 99 / 100);
  localparam logic [33:0] TOL1_HI = 34'(MCLK_HZ * 101 / 100);
  localparam logic [33:0] TOL5_LO = 34'(MCLK_HZ * 95 / 100);
  localparam logic [33:0] TOL5_HI = 34'(MCLK_HZ * 105 / 100);
  localparam logic [35:0] MCLK_36 = 36'(MCLK_HZ);

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_OFFSET = 4'b0010,
    ST_SHIFT  = 4'b0100,
    ST_PUSH   = 4'b1000
  } aprx_state_e;

  typedef struct packed {
    logic       latch_edge;
    logic       int_fs_sel;
    logic       int_bclk_sel;
    logic [4:0] offset;
  } aprx_rx_cfg_t;

  typedef struct packed {
    logic [5:0] rate_code;
    logic       tol_widen;
    logic       custom_clk;
  } aprx_clk_cfg_t;

  typedef struct packed {
    logic [WORD_BITS-1:0] ch1;
    logic [WORD_BITS-1:0] ch0;
  } aprx_sample_t;

  typedef struct packed {
    aprx_rx_cfg_t   rx_cfg;
    aprx_clk_cfg_t  clk_cfg;
    logic [7:0]     rdata;
    logic [3:0]     sync1;
    logic [3:0]     sync2;
    logic           bclk_prev;
    logic           fs_prev;
    logic [7:0]     int_cnt;
    logic           int_bclk;
    logic [5:0]     int_bit;
    logic           int_fs;
    aprx_state_e    fsm;
    logic [4:0]     off_left;
    logic [3:0]     bit_cnt;
    logic [WORD_BITS-1:0] sh0;
    logic [WORD_BITS-1:0] sh1;
    logic           push_valid;
    aprx_sample_t   push_data;
    logic [13:0]    per_cnt;
    logic [13:0]    period;
    logic [5:0]     scan_idx;
    logic           scan_hit;
    logic [5:0]     hit_code;
    logic [5:0]     det_code;
    logic           locked;
    logic [7:0]     div;
    logic [5:0]     div_code;
  } aprx_top_t;

  // ==========================================================
  // Typical rate of each code in Hz
  function automatic logic [19:0] rate_hz(input logic [5:0] code);
    unique case (code)
      6'd1:    rate_hz = 20'd768000;
      6'd2:    rate_hz = 20'd614400;
      6'd3:    rate_hz = 20'd512000;
      6'd4:    rate_hz = 20'd438857;
      6'd5:    rate_hz = 20'd384000;
      6'd6:    rate_hz = 20'd341333;
      6'd7:    rate_hz = 20'd307200;
      6'd8:    rate_hz = 20'd256000;
      6'd9:    rate_hz = 20'd219429;
      6'd10:   rate_hz = 20'd192000;
      6'd11:   rate_hz = 20'd170667;
      6'd12:   rate_hz = 20'd153600;
      6'd13:   rate_hz = 20'd128000;
      6'd14:   rate_hz = 20'd109714;
      6'd15:   rate_hz = 20'd96000;
      6'd16:   rate_hz = 20'd85333;
      6'd17:   rate_hz = 20'd76800;
      6'd18:   rate_hz = 20'd64000;
      6'd19:   rate_hz = 20'd54857;
      6'd20:   rate_hz = 20'd48000;
      6'd21:   rate_hz = 20'd42667;
      6'd22:   rate_hz = 20'd38400;
      6'd23:   rate_hz = 20'd32000;
      6'd24:   rate_hz = 20'd27429;
      6'd25:   rate_hz = 20'd24000;
      6'd26:   rate_hz = 20'd21333;
      6'd27:   rate_hz = 20'd19200;
      6'd28:   rate_hz = 20'd16000;
      6'd29:   rate_hz = 20'd13714;
      6'd30:   rate_hz = 20'd12000;
      6'd31:   rate_hz = 20'd10667;
      6'd32:   rate_hz = 20'd9600;
      6'd33:   rate_hz = 20'd8000;
      6'd34:   rate_hz = 20'd6857;
      6'd35:   rate_hz = 20'd6000;
      6'd36:   rate_hz = 20'd5333;
      6'd37:   rate_hz = 20'd4800;
      6'd38:   rate_hz = 20'd4000;
      6'd39:   rate_hz = 20'd3429;
      6'd40:   rate_hz = 20'd3000;
      default: rate_hz = 20'd0;
    endcase
  endfunction : rate_hz

endpackage : aprx_pkg

//--- verilog/aprx_top.sv
`timescale 1ns/1ps

// ============================================================
// Sample FIFO with registered output stage
module aprx_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             out_valid;
    logic [WIDTH-1:0] out_data;
  } aprx_fifo_t;

  aprx_fifo_t             s;
  aprx_fifo_t             next_s;
  logic       [WIDTH-1:0] mem [DEPTH];
  logic                   full;
  logic                   empty;
  logic                   do_wr;

  assign full  = (s.wr_ptr[AW] != s.rd_ptr[AW]) &&
                 (s.wr_ptr[AW-1:0] == s.rd_ptr[AW-1:0]);
  assign empty = (s.wr_ptr == s.rd_ptr);
  assign do_wr = in_valid_in && !full;
  assign in_ready_out  = !full;
  assign out_valid_out = s.out_valid;
  assign out_data_out  = s.out_data;

  always_comb begin
    next_s = s;
    if (do_wr) begin
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (out_ready_in) begin
      next_s.out_valid = 1'b0;
    end
    if ((!s.out_valid || out_ready_in) && !empty) begin
      next_s.out_valid = 1'b1;
      next_s.out_data  = mem[s.rd_ptr[AW-1:0]];
      next_s.rd_ptr    = s.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (do_wr) begin
      mem[s.wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : aprx_fifo

// ============================================================
// Receive port configuration, latch and rate detect
module aprx_top (
  input  wire logic                 mclk_in,
  input  wire logic                 rst_in,
  input  wire logic                 reg_write_in,
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic [7:0]           reg_wdata_in,
  output logic      [7:0]           reg_rdata_out,
  input  wire logic                 controller_mode_in,
  input  wire logic                 bit_clock_polarity_setting_in,
  input  wire logic [7:0]           custom_bclk_half_div_in,
  input  wire logic                 bit_clock_in,
  input  wire logic                 frame_sync_in,
  input  wire logic                 data_primary_in,
  input  wire logic                 data_secondary_in,
  output logic                      bit_clock_out,
  output logic                      frame_sync_out,
  output logic      [5:0]           detected_rate_code_out,
  output logic                      rate_locked_out,
  output logic                      sample_valid_out,
  input  wire logic                 sample_ready_in,
  output aprx_pkg::aprx_sample_t    sample_data_out
);

  aprx_pkg::aprx_top_t s;
  aprx_pkg::aprx_top_t next_s;
  logic                fifo_ready;
  logic                bclk_src;
  logic                fs_src;
  logic                edge_now;
  logic                frame_start;
  logic                auto_rate;
  logic [5:0]          use_code;
  logic [19:0]         scan_rate;
  logic [19:0]         use_rate;
  logic [33:0]         per_prod;
  logic [35:0]         div_prod;
  logic                in_tol;

  // ==========================================================
  // Combinational helpers
  assign auto_rate = (s.clk_cfg.rate_code == aprx_pkg::RATE_AUTO); // R5
  assign use_code  = auto_rate ? s.det_code : s.clk_cfg.rate_code;
  assign scan_rate = aprx_pkg::rate_hz(auto_rate ? s.scan_idx
                                                 : s.clk_cfg.rate_code);
  assign use_rate  = aprx_pkg::rate_hz(use_code); // R6
  assign per_prod  = 34'(s.period) * 34'(scan_rate);
  assign div_prod  = {36'(s.div) * 36'(use_rate)} << 7;
  // R8
  assign in_tol = s.clk_cfg.tol_widen ?
    (per_prod >= aprx_pkg::TOL5_LO && per_prod <= aprx_pkg::TOL5_HI) :
    (per_prod >= aprx_pkg::TOL1_LO && per_prod <= aprx_pkg::TOL1_HI);
  // R3 R10
  assign bclk_src = (controller_mode_in && s.rx_cfg.int_bclk_sel) ?
                    s.int_bclk : s.sync2[0];
  // R2 R10
  assign fs_src   = (controller_mode_in && s.rx_cfg.int_fs_sel) ?
                    s.int_fs : s.sync2[1];
  // R1
  assign edge_now = (bit_clock_polarity_setting_in ^ s.rx_cfg.latch_edge) ?
                    (!bclk_src && s.bclk_prev) : (bclk_src && !s.bclk_prev);
  assign frame_start = edge_now && fs_src && !s.fs_prev;

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.sync1 = {data_secondary_in, data_primary_in,
                    frame_sync_in, bit_clock_in};
    next_s.sync2 = s.sync1;
    next_s.bclk_prev = bclk_src;
    // Register port
    if (reg_write_in && reg_addr_in == aprx_pkg::RX_CFG_ADDR) begin
      next_s.rx_cfg = reg_wdata_in;
    end
    if (reg_write_in && reg_addr_in == aprx_pkg::CLK_CFG_ADDR) begin
      next_s.clk_cfg = reg_wdata_in;
    end
    unique case (reg_addr_in)
      aprx_pkg::RX_CFG_ADDR:  next_s.rdata = s.rx_cfg;
      aprx_pkg::CLK_CFG_ADDR: next_s.rdata = s.clk_cfg;
      default:                next_s.rdata = 8'h00;
    endcase
    // Internal bit clock and frame sync generator
    if (s.int_cnt + 8'h01 >= s.div) begin
      next_s.int_cnt  = 8'h00;
      next_s.int_bclk = !s.int_bclk;
      if (!s.int_bclk) begin
        next_s.int_bit = s.int_bit + 6'h01;
        next_s.int_fs  = (6'(s.int_bit + 6'h01) < 6'(aprx_pkg::HALF_FRAME));
      end
    end else begin
      next_s.int_cnt = s.int_cnt + 8'h01;
    end
    // Divider: software value or searched from rate
    if (s.clk_cfg.custom_clk) begin
      next_s.div = custom_bclk_half_div_in; // R9
    end else if (use_code != s.div_code) begin
      next_s.div_code = use_code; // R9
      next_s.div      = 8'h01;
    end else if (div_prod < aprx_pkg::MCLK_36 && s.div != 8'hFF) begin
      next_s.div = s.div + 8'h01; // R9
    end
    // Frame period measurement
    if (s.per_cnt != 14'h3FFF) begin
      next_s.per_cnt = s.per_cnt + 14'h0001;
    end
    if (frame_start) begin
      next_s.period  = s.per_cnt;
      next_s.per_cnt = 14'h0000;
    end
    // Rate scan over codes 1 to 40
    if (auto_rate) begin
      next_s.scan_idx = (s.scan_idx >= aprx_pkg::RATE_CODE_MAX) ?
                        6'h01 : s.scan_idx + 6'h01;
      if (in_tol && s.scan_idx != 6'h00) begin
        next_s.scan_hit = 1'b1; // R5
        next_s.hit_code = s.scan_idx;
      end
      if (s.scan_idx >= aprx_pkg::RATE_CODE_MAX) begin
        next_s.locked   = s.scan_hit || in_tol;
        next_s.det_code = in_tol ? s.scan_idx : s.hit_code;
        next_s.scan_hit = 1'b0;
      end
    end else begin
      next_s.det_code = s.clk_cfg.rate_code; // R6
      next_s.locked   = in_tol;
    end
    // Data latch sequence
    next_s.push_valid = 1'b0;
    if (edge_now) begin
      next_s.fs_prev = fs_src;
    end
    unique case (s.fsm)
      aprx_pkg::ST_IDLE, aprx_pkg::ST_OFFSET, aprx_pkg::ST_SHIFT: begin
        if (frame_start) begin
          next_s.off_left = s.rx_cfg.offset; // R4
          next_s.bit_cnt  = 4'h0;
          next_s.fsm      = aprx_pkg::ST_OFFSET;
          if (s.rx_cfg.offset == 5'h00) begin
            next_s.sh0     = {s.sh0[14:0], s.sync2[2]};
            next_s.sh1     = {s.sh1[14:0], s.sync2[3]};
            next_s.bit_cnt = 4'h1;
            next_s.fsm     = aprx_pkg::ST_SHIFT;
          end
        end else if (edge_now && s.fsm == aprx_pkg::ST_OFFSET) begin
          next_s.off_left = s.off_left - 5'h01; // R4
          if (s.off_left == 5'h01) begin
            next_s.sh0     = {s.sh0[14:0], s.sync2[2]};
            next_s.sh1     = {s.sh1[14:0], s.sync2[3]};
            next_s.bit_cnt = 4'h1;
            next_s.fsm     = aprx_pkg::ST_SHIFT;
          end
        end else if (edge_now && s.fsm == aprx_pkg::ST_SHIFT) begin
          next_s.sh0     = {s.sh0[14:0], s.sync2[2]};
          next_s.sh1     = {s.sh1[14:0], s.sync2[3]};
          next_s.bit_cnt = s.bit_cnt + 4'h1;
          if (s.bit_cnt == 4'hF) begin
            next_s.fsm = aprx_pkg::ST_PUSH;
          end
        end
      end
      aprx_pkg::ST_PUSH: begin
        if (fifo_ready) begin
          next_s.push_valid    = 1'b1;
          next_s.push_data.ch0 = s.sh0;
          next_s.push_data.ch1 = s.sh1;
          next_s.fsm           = aprx_pkg::ST_IDLE;
        end
      end
      default: next_s.fsm = aprx_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s         <= '0;
      s.rx_cfg  <= aprx_pkg::RX_CFG_RESET;
      s.clk_cfg <= aprx_pkg::CLK_CFG_RESET;
      s.fsm     <= aprx_pkg::ST_IDLE;
      s.div     <= 8'h01;
      s.per_cnt <= 14'h3FFF;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_out          = s.rdata;
  assign bit_clock_out          = s.int_bclk;
  assign frame_sync_out         = s.int_fs;
  assign detected_rate_code_out = s.det_code;
  assign rate_locked_out        = s.locked;

  aprx_fifo #(
    .WIDTH (2 * aprx_pkg::WORD_BITS),
    .DEPTH (aprx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .in_valid_in   (s.push_valid),
    .in_ready_out  (fifo_ready),
    .in_data_in    (s.push_data),
    .out_valid_out (sample_valid_out),
    .out_ready_in  (sample_ready_in),
    .out_data_out  (sample_data_out)
  );

endmodule : aprx_top

//--- dv/aprx_props.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker
module aprx_props (
  input wire logic                   mclk_in,
  input wire logic                   rst_in,
  input wire logic                   reg_write_in,
  input wire logic [7:0]             reg_addr_in,
  input wire logic [7:0]             reg_wdata_in,
  input wire logic [7:0]             reg_rdata_out,
  input wire logic [5:0]             detected_rate_code_out,
  input wire logic                   rate_locked_out,
  input wire logic                   sample_valid_out,
  input wire logic                   sample_ready_in,
  input wire aprx_pkg::aprx_sample_t sample_data_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_wr(logic [7:0] a);
    (reg_write_in && reg_addr_in == a) ##1
    (!reg_write_in && reg_addr_in == a);
  endsequence
  property p_rd_rx;
    s_wr(8'h26) |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_rd_rx: assert property (p_rd_rx)
    else $error("receive config readback wrong");
  property p_rd_clk;
    s_wr(8'h32) |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_rd_clk: assert property (p_rd_clk)
    else $error("clock config readback wrong");
  property p_unmap;
    !(reg_addr_in inside {8'h26, 8'h32}) |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_fixed;
    logic [5:0] c;
    (reg_write_in && reg_addr_in == 8'h32 &&
     reg_wdata_in[7:2] inside {[1:40]}, c = reg_wdata_in[7:2])
    ##1 (!reg_write_in) [*8] |-> ##[0:45] detected_rate_code_out == c;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("programmed rate code not reported");
  property p_rsv;
    detected_rate_code_out <= 6'd40;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("rate code out of range");
  property p_lock;
    rate_locked_out |-> detected_rate_code_out inside {[1:40]};
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock without valid code");
  property p_hold;
    sample_valid_out && !sample_ready_in |=>
      sample_valid_out && $stable(sample_data_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("sample dropped before taken");
  property p_rst;
    $fell(rst_in) |-> !rate_locked_out [*3];
  endproperty
  a_rst: assert property (p_rst)
    else $error("lock right after reset");
endmodule : aprx_props

bind aprx_top aprx_props u_props (.*);

//--- dv/aprx_host.sv
`timescale 1ns/1ps
// ==========================================================
// Serial link host model
module aprx_host (
  input  wire logic mclk_in,
  output logic      bclk_out,
  output logic      fs_out,
  output logic      d0_out,
  output logic      d1_out
);
  initial begin
    bclk_out = 1'b0;
    fs_out   = 1'b0;
    d0_out   = 1'b0;
    d1_out   = 1'b0;
  end
  // One frame of 64 bit clocks, MSB shifted by off
  task automatic frame(input int h, input logic inv, input int off,
                       input logic [15:0] w0, input logic [15:0] w1);
    int k;
    for (int b = 0; b < 64; b++) begin
      k = b - off;
      bclk_out = inv;
      fs_out = (b < 32);
      d0_out = (k >= 0 && k < 16) ? w0[15-k] : ~d0_out;
      d1_out = (k >= 0 && k < 16) ? w1[15-k] : ~d1_out;
      repeat (h) @(negedge mclk_in);
      bclk_out = ~inv;
      repeat (h) @(negedge mclk_in);
    end
    bclk_out = 1'b0;
    fs_out = 1'b0;
    d0_out = ~d0_out;
    d1_out = ~d1_out;
    // Idle gap so back to back frames never reassign in one step
    @(negedge mclk_in);
  endtask : frame
endmodule : aprx_host

//--- dv/aprx_top_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Testbench
module aprx_top_tb;
  logic                   mclk_in = 0, rst_in = 1, reg_write_in = 0;
  logic                   controller_mode_in = 0, sample_ready_in = 0;
  logic                   bit_clock_polarity_setting_in = 0;
  logic [7:0]             reg_addr_in = 0, reg_wdata_in = 0;
  logic [7:0]             custom_bclk_half_div_in = 8'h04;
  logic [7:0]             reg_rdata_out;
  logic                   bit_clock_in, frame_sync_in, data_primary_in;
  logic                   data_secondary_in, bit_clock_out, frame_sync_out;
  logic                   rate_locked_out, sample_valid_out;
  logic [5:0]             detected_rate_code_out;
  aprx_pkg::aprx_sample_t sample_data_out;
  int                     errors = 0, compares = 0;
  aprx_top dut (.*);
  aprx_host host (.mclk_in(mclk_in), .bclk_out(bit_clock_in),
    .fs_out(frame_sync_in), .d0_out(data_primary_in),
    .d1_out(data_secondary_in));
  always #25 mclk_in = ~mclk_in;
  // ========================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, d);
    @(negedge mclk_in);
    reg_write_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge mclk_in);
    reg_write_in = 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, e);
    @(negedge mclk_in);
    reg_addr_in = a;
    repeat (2) @(negedge mclk_in);
    chk("reg", reg_rdata_out, e);
  endtask : rchk
  task automatic wait_valid(input int n, input logic e);
    logic v;
    v = 1'b0;
    for (int i = 0; i < n && v !== 1'b1; i++) begin
      @(negedge mclk_in);
      v = sample_valid_out;
    end
    chk("valid", v, e);
    if (v !== e && e) stop_test();
  endtask : wait_valid
  task automatic take;
    @(negedge mclk_in);
    sample_ready_in = 1'b1;
    @(negedge mclk_in);
    sample_ready_in = 1'b0;
  endtask : take
  function automatic logic sg(input bit f);
    return f ? frame_sync_out : bit_clock_out;
  endfunction : sg
  task automatic msr(input bit f, input int e);
    int c;
    c = 0;
    for (int i = 0; i < 3000 && sg(f) !== 1'b0; i++) @(negedge mclk_in);
    for (int i = 0; i < 3000 && sg(f) !== 1'b1; i++) @(negedge mclk_in);
    for (int i = 0; i < 3000 && sg(f) === 1'b1; i++) begin
      c++;
      @(negedge mclk_in);
    end
    chk("high_len", c, e);
  endtask : msr
  // ========================================================
  // Main sequence
  logic [6:0] cs[4] = '{7'h00, 7'h20, 7'h43, 7'h7F};
  logic [7:0] rc[6] = '{8'h00, 8'h00, 8'h02, 8'h5A, 8'h7A, 8'hA0};
  int         rh[6] = '{13, 4, 4, 4, 4, 4};
  logic [5:0] re[6] = '{30, 0, 22, 22, 30, 40};
  logic       rl[6] = '{1, 0, 1, 1, 0, 0};
  initial begin
    int n;
    repeat (5) @(negedge mclk_in);
    rst_in = 1'b0;
    rchk(8'h26, 8'h00);
    rchk(8'h32, 8'h00);
    wr(8'h26, 8'hA3);
    rchk(8'h26, 8'hA3);
    wr(8'h32, 8'h5A);
    rchk(8'h32, 8'h5A);
    wr(8'h27, 8'hFF);
    rchk(8'h27, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h26, {cs[i][5], 2'b00, cs[i][4:0]});
      bit_clock_polarity_setting_in = cs[i][6];
      host.frame(4, cs[i][6] ^ cs[i][5], cs[i][4:0], 16'hA5C3 + i, 16'h3C5A);
      wait_valid(100, 1'b1);
      chk("sample", sample_data_out, {16'h3C5A, 16'hA5C3 + 16'(i)});
      take();
    end
    wr(8'h26, 8'h00);
    bit_clock_polarity_setting_in = 1'b0;
    for (int i = 0; i < 18; i++) host.frame(4, 0, 0, 16'h1000 + i, 16'h2000);
    n = 0;
    for (int i = 0; i < 60; i++) begin
      @(negedge mclk_in);
      if (sample_valid_out === 1'b1 && !sample_ready_in) begin
        chk("fifo", sample_data_out,
            {16'h2000, 16'h1000 + 16'(n)});
        n++;
        sample_ready_in = 1'b1;
      end else sample_ready_in = 1'b0;
    end
    chk("fifo_count", n, 18);
    sample_ready_in = 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(8'h32, rc[i]);
      repeat (3) host.frame(rh[i], 0, 0, 16'h0F0F, 16'hF0F0);
      repeat (50) @(negedge mclk_in);
      chk("lock", rate_locked_out, rl[i]);
      if (rc[i][7:2] != 0 || rl[i]) chk("code", detected_rate_code_out, re[i]);
    end
    controller_mode_in = 1'b1;
    wr(8'h32, 8'h79);
    msr(0, 4);
    msr(1, 256);
    wr(8'h32, 8'h78);
    repeat (300) @(negedge mclk_in);
    msr(0, (20000000 + 1535999) / 1536000);
    wr(8'h32, 8'h79);
    wr(8'h26, 8'h20);
    repeat (600) @(negedge mclk_in);
    wait_valid(1500, 1'b0);
    wr(8'h26, 8'h60);
    wait_valid(1500, 1'b1);
    controller_mode_in = 1'b0;
    repeat (600) @(negedge mclk_in);
    wait_valid(1500, 1'b0);
    stop_test();
  end
endmodule : aprx_top_tb
